/* shared/uss_pkg.sv */
// constants, register map and state codes for the usb suspend and stream controller
// assumes a single 50 MHz core clock and an axi4-lite register port
// Overview of operation
// - in device mode a resume begun by the host clears the low-power suspend bit by itself.
// - a wakeup with port suspended, low-power clear raises port change; the bit stays clear.
// - in host mode a wakeup with low-power set but power-down and clock gate clear raises remote-wakeup.
// - a streaming transmit underrun while sending an out packet retries that transaction.
// - with stream disable at 1 a whole packet is loaded before transmission starts.
// - in device mode a receive overrun stops token answers until the overrun is gone.
// - in host mode an unacceptable packet gets no handshake, is dropped and flags rx error.
// - writing 1 to the charger-detection disable bit turns charger detection off.
package uss_pkg;
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_PORT     = 8'h04;
  localparam logic [7:0] ADDR_PWD      = 8'h08;
  localparam logic [7:0] ADDR_CLK_GATE = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam logic [7:0] ADDR_STATUS   = 8'h18;
  localparam logic [7:0] ADDR_TX_PKT   = 8'h1c;
  // controller_mode_reg fields
  localparam int CTRL_HOST_BIT = 0;
  localparam int CTRL_STRM_BIT = 1;
  localparam int CTRL_CHG_BIT  = 2;
  localparam int CTRL_THR_LSB  = 8;
  localparam logic [7:0] THR_RESET = 8'h10;
  // port_status_control fields
  localparam int PORT_SUSPD_BIT  = 0;
  localparam int PORT_LPS_BIT    = 1;
  localparam int PORT_RESUME_BIT = 2;
  // irq status and mask layout
  localparam int IRQ_PCHG  = 0;
  localparam int IRQ_RWU   = 1;
  localparam int IRQ_UNDER = 2;
  localparam int IRQ_OVER  = 3;
  localparam int IRQ_RXERR = 4;
  localparam int IRQ_W     = 5;
  // tx packet register: length in low bits, go bit
  localparam int TXPKT_GO_BIT = 31;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_FILL  = 2'b01,
    TX_SEND  = 2'b10,
    TX_RETRY = 2'b11
  } uss_tx_e;
endpackage

/* src/uss_ctrl.sv */
// usb suspend, resume, wakeup and streaming control with its axi4-lite registers
// assumes link-side inputs are synchronous to core_clk and software owns the suspend sequence
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
module uss_ctrl
  import uss_pkg::*;
#(
  parameter int PWD_W = 8,
  parameter int LEN_W = 11
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  output logic [1:0]            s_axi_bresp,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  input  wire logic [7:0]       s_axi_araddr,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  input  wire logic             deviceAttached,
  input  wire logic             busSuspendSeen,
  input  wire logic             lineResume,
  input  wire logic             rxOverrun,
  input  wire logic             rxPacketEnd,
  input  wire logic             rxAcceptable,
  input  wire logic             txLoadStrobe,
  input  wire logic             txSendStrobe,
  output logic                  irq,
  output logic                  phy_low_power_suspend,
  output logic [PWD_W-1:0]      phy_power_down_bits,
  output logic                  phy_clock_gate,
  output logic                  chargerDetectOff,
  output logic                  resumeDrive,
  output logic                  tokenAnswerEn,
  output logic                  rxHandshake,
  output logic                  rxDiscard,
  output logic                  rxError,
  output logic                  txStart,
  output logic                  txActive,
  output logic                  txRetry
);
  logic             hostMode;
  logic             stream_disable;
  logic [7:0]       tx_fifo_fill_threshold;
  logic             port_suspended;
  logic [IRQ_W-1:0] irqStatus;
  logic [IRQ_W-1:0] irqMask;
  logic [LEN_W-1:0] txPktLen;
  logic             txPktGo;
  logic             txUnderrun;
  logic             overrunQ;
  logic [7:0]       awAddrQ;
  logic [31:0]      wDataQ;
  logic [3:0]       wStrbQ;
  logic             doWrite;
  logic             addrOk;
  logic [31:0]      wr;
  logic [31:0]      regRead;
  logic [IRQ_W-1:0] irqSet;
  logic             evPortChg;
  logic             evRwu;
  logic             lpsAllowed;

  // byte-lane merge of the captured write into an old register value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  // axi4-lite write channel
  assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_comb begin
    unique case (awAddrQ)
      ADDR_CTRL, ADDR_PORT, ADDR_PWD, ADDR_CLK_GATE,
      ADDR_IRQ_STAT, ADDR_IRQ_MASK, ADDR_STATUS, ADDR_TX_PKT: addrOk = 1'b1;
      default: addrOk = 1'b0;
    endcase
  end

  assign wr = merge(32'h0000_0000, wDataQ, wStrbQ);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awAddrQ       <= 8'h00;
      wDataQ        <= 32'h0000_0000;
      wStrbQ        <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddrQ       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wDataQ       <= s_axi_wdata;
        wStrbQ       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= addrOk ? RESP_OKAY : RESP_SLVERR;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi4-lite read channel
  always_comb begin
    regRead = 32'h0000_0000;
    unique case (s_axi_araddr)
      ADDR_CTRL: begin
        regRead[CTRL_HOST_BIT] = hostMode;
        regRead[CTRL_STRM_BIT] = stream_disable;
        regRead[CTRL_CHG_BIT]  = chargerDetectOff;
        regRead[CTRL_THR_LSB +: 8] = tx_fifo_fill_threshold;
      end
      ADDR_PORT: begin
        regRead[PORT_SUSPD_BIT] = port_suspended;
        regRead[PORT_LPS_BIT]   = phy_low_power_suspend;
      end
      ADDR_PWD:      regRead[PWD_W-1:0] = phy_power_down_bits;
      ADDR_CLK_GATE: regRead[0] = phy_clock_gate;
      ADDR_IRQ_STAT: regRead[IRQ_W-1:0] = irqStatus;
      ADDR_IRQ_MASK: regRead[IRQ_W-1:0] = irqMask;
      ADDR_STATUS:   regRead[2:0] = {deviceAttached, !tokenAnswerEn, txActive};
      ADDR_TX_PKT:   regRead[LEN_W-1:0] = txPktLen;
      default:       regRead = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= regRead;
      s_axi_rresp   <= (s_axi_araddr[1:0] == 2'b00 && s_axi_araddr <= ADDR_TX_PKT)
                       ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // mode, stream and charger control
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hostMode               <= 1'b0;
      stream_disable         <= 1'b0;
      chargerDetectOff       <= 1'b0;
      tx_fifo_fill_threshold <= THR_RESET;
    end else if (doWrite && awAddrQ == ADDR_CTRL) begin
      if (wStrbQ[0]) begin
        hostMode         <= wr[CTRL_HOST_BIT];
        stream_disable   <= wr[CTRL_STRM_BIT];
        chargerDetectOff <= wr[CTRL_CHG_BIT];
      end
      if (wStrbQ[1]) begin
        tx_fifo_fill_threshold <= wr[CTRL_THR_LSB +: 8];
      end
    end
  end

  // port suspend and phy low-power
  // host mode only lets software set low-power suspend on a suspended or empty port
  assign lpsAllowed = !hostMode || port_suspended || !deviceAttached;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      port_suspended <= 1'b0;
    end else if (!hostMode && lineResume) begin
      port_suspended <= 1'b0;
    end else if (!hostMode && busSuspendSeen) begin
      port_suspended <= 1'b1;
    end else if (doWrite && awAddrQ == ADDR_PORT && wStrbQ[0]) begin
      port_suspended <= wr[PORT_SUSPD_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      phy_low_power_suspend <= 1'b0;
    end else if (!hostMode && lineResume) begin
      phy_low_power_suspend <= 1'b0;
    end else if (doWrite && awAddrQ == ADDR_PORT && wStrbQ[0]) begin
      // wakeups never set this bit; only software does
      phy_low_power_suspend <= wr[PORT_LPS_BIT] && lpsAllowed;
    end
  end

  // device-initiated resume is refused while the phy is still in low power
  always_ff @(posedge core_clk) begin
    if (reset) begin
      resumeDrive <= 1'b0;
    end else begin
      resumeDrive <= doWrite && awAddrQ == ADDR_PORT && wStrbQ[0] && wr[PORT_RESUME_BIT]
                     && !hostMode && !phy_low_power_suspend;
    end
  end

  // power-down bits and clock gate follow software only; wakeups never set them
  always_ff @(posedge core_clk) begin
    if (reset) begin
      phy_power_down_bits <= '0;
    end else if (doWrite && awAddrQ == ADDR_PWD) begin
      phy_power_down_bits <= PWD_W'(merge(32'(phy_power_down_bits), wDataQ, wStrbQ));
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      phy_clock_gate <= 1'b0;
    end else if (doWrite && awAddrQ == ADDR_CLK_GATE && wStrbQ[0]) begin
      phy_clock_gate <= wr[0];
    end
  end

  // wakeup events
  assign evPortChg = lineResume && (hostMode ? (port_suspended && !phy_low_power_suspend)
                                             : 1'b1);
  assign evRwu = lineResume && hostMode && phy_low_power_suspend
                 && phy_power_down_bits == '0 && !phy_clock_gate;

  // receive side
  always_ff @(posedge core_clk) begin
    if (reset) begin
      overrunQ      <= 1'b0;
      tokenAnswerEn <= 1'b1;
    end else begin
      overrunQ      <= rxOverrun;
      tokenAnswerEn <= hostMode || !rxOverrun;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rxHandshake <= 1'b0;
      rxDiscard   <= 1'b0;
      rxError     <= 1'b0;
    end else begin
      rxHandshake <= rxPacketEnd && (hostMode ? rxAcceptable : !rxOverrun);
      rxDiscard   <= rxPacketEnd && hostMode && !rxAcceptable;
      rxError     <= rxPacketEnd && hostMode && !rxAcceptable;
    end
  end

  // transmit packet request
  always_ff @(posedge core_clk) begin
    if (reset) begin
      txPktLen <= '0;
      txPktGo  <= 1'b0;
    end else begin
      txPktGo <= 1'b0;
      if (doWrite && awAddrQ == ADDR_TX_PKT) begin
        txPktLen <= wDataQ[LEN_W-1:0];
        txPktGo  <= wDataQ[TXPKT_GO_BIT];
      end
    end
  end

  uss_tx_gate #(
    .LEN_W (LEN_W)
  ) u_tx_gate (
    .core_clk      (core_clk),
    .reset         (reset),
    .streamDisable (stream_disable),
    .fillThreshold (tx_fifo_fill_threshold),
    .pktGo         (txPktGo),
    .pktLen        (txPktLen),
    .loadStrobe    (txLoadStrobe),
    .sendStrobe    (txSendStrobe),
    .txStart       (txStart),
    .txActive      (txActive),
    .txRetry       (txRetry),
    .txUnderrun    (txUnderrun),
    .txDone        ()
  );

  // interrupts: sticky, write one to clear, set wins
  assign irqSet = {rxPacketEnd && hostMode && !rxAcceptable,
                   rxOverrun && !overrunQ && !hostMode,
                   txUnderrun, evRwu, evPortChg};

  always_ff @(posedge core_clk) begin
    if (reset) begin
      irqStatus <= '0;
    end else if (doWrite && awAddrQ == ADDR_IRQ_STAT) begin
      irqStatus <= (irqStatus & ~wr[IRQ_W-1:0]) | irqSet;
    end else begin
      irqStatus <= irqStatus | irqSet;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      irqMask <= '0;
    end else if (doWrite && awAddrQ == ADDR_IRQ_MASK && wStrbQ[0]) begin
      irqMask <= wr[IRQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus & irqMask);
    end
  end
endmodule

/* src/uss_tx_gate.sv */
// transmit start gate: decides when a packet may go out and retries after underrun
// assumes one load strobe per byte into the fifo and one send strobe per byte taken
`timescale 1ns/10ps
module uss_tx_gate
  import uss_pkg::*;
#(
  parameter int LEN_W = 11
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             streamDisable,
  input  wire logic [7:0]       fillThreshold,
  input  wire logic             pktGo,
  input  wire logic [LEN_W-1:0] pktLen,
  input  wire logic             loadStrobe,
  input  wire logic             sendStrobe,
  output logic                  txStart,
  output logic                  txActive,
  output logic                  txRetry,
  output logic                  txUnderrun,
  output logic                  txDone
);
  uss_tx_e          state;
  logic [LEN_W-1:0] loaded;
  logic [LEN_W-1:0] sent;
  logic [LEN_W-1:0] len;
  logic             allLoaded;
  logic             thrReached;

  assign allLoaded  = (loaded == len);
  assign thrReached = (loaded >= LEN_W'(fillThreshold));

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state      <= TX_IDLE;
      loaded     <= '0;
      sent       <= '0;
      len        <= '0;
      txStart    <= 1'b0;
      txActive   <= 1'b0;
      txRetry    <= 1'b0;
      txUnderrun <= 1'b0;
      txDone     <= 1'b0;
    end else begin
      txStart    <= 1'b0;
      txRetry    <= 1'b0;
      txUnderrun <= 1'b0;
      txDone     <= 1'b0;
      if (loadStrobe && state != TX_IDLE && !allLoaded) begin
        loaded <= loaded + 1'b1;
      end
      unique case (state)
        TX_IDLE: begin
          if (pktGo && pktLen != '0) begin
            len    <= pktLen;
            loaded <= '0;
            sent   <= '0;
            state  <= TX_FILL;
          end
        end
        TX_FILL: begin
          // whole packet when streaming is off, else threshold
          if (allLoaded || (!streamDisable && thrReached)) begin
            state    <= TX_SEND;
            txStart  <= 1'b1;
            txActive <= 1'b1;
          end
        end
        TX_SEND: begin
          if (sendStrobe) begin
            if (sent == LEN_W'(len - 1'b1)) begin
              state    <= TX_IDLE;
              txActive <= 1'b0;
              txDone   <= 1'b1;
            end else if (sent == loaded) begin
              // fifo ran dry mid packet: abort and retry whole transaction
              state      <= TX_RETRY;
              sent       <= '0;
              txActive   <= 1'b0;
              txUnderrun <= 1'b1;
            end else begin
              sent <= sent + 1'b1;
            end
          end
        end
        TX_RETRY: begin
          // retry only once the packet is complete so it cannot underrun again
          if (allLoaded) begin
            state    <= TX_SEND;
            txRetry  <= 1'b1;
            txStart  <= 1'b1;
            txActive <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule

/* verif/tb_top.sv */
// self-checking bench for uss_ctrl with a usb peer model
// assumes a 50 MHz core clock and a synchronous active-high reset
`timescale 1ns/10ps
module tb_top
  import uss_pkg::*;
;
  logic        core_clk = 1'h0, reset = 1'h1, txLoadStrobe = 1'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, phy_power_down_bits;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb = 4'hf, strb = 4'hf, sendGap = 4'h3;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        irq, phy_low_power_suspend, phy_clock_gate, chargerDetectOff, resumeDrive;
  logic        tokenAnswerEn, rxHandshake, rxDiscard, rxError, txStart, txActive, txRetry;
  logic        txSendStrobe, deviceAttached, busSuspendSeen, lineResume, rxOverrun;
  logic        rxPacketEnd, rxAcceptable, resumeSeen = 1'h0, retrySeen = 1'h0;
  int          mismatches = 0, n_compared = 0, i;

  uss_ctrl uss_ctrl_i (.*);
  uss_usb_peer uss_usb_peer_i (.*);

  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (resumeDrive === 1'h1) resumeSeen <= 1'h1;
    if (txRetry === 1'h1) retrySeen <= 1'h1;
  end

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bound();
    if (i >= 60) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  task automatic settle();
    @(posedge core_clk);
    #1;
  endtask
  task automatic ev(input int k, input logic ok);
    uss_usb_peer_i.event_pulse(k, ok);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= strb;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (i = 0; i < 60; i++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    bound();
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (i = 0; i < 60; i++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    bound();
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
    #1;
  endtask
  task automatic load(input int n);
    repeat (n) begin
      @(posedge core_clk);
      txLoadStrobe <= 1'h1;
      @(posedge core_clk);
      txLoadStrobe <= 1'h0;
    end
  endtask
  task automatic wait_tx(input logic v);
    for (i = 0; i < 60 && txActive !== v; i++) @(posedge core_clk);
    bound();
  endtask

  task automatic t_reset();
    chk(tokenAnswerEn, 1'h1);
    chk(irq, 1'h0);
    rd(ADDR_CTRL);
    chk(rv, {16'h0, THR_RESET, 8'h00});
    rd(8'h20);
    chk(rs, RESP_SLVERR);
    wr(8'h02, 32'h1);
    chk(rs, RESP_SLVERR);
    strb = 4'h1;
    wr(ADDR_CTRL, 32'h0000_ff04);
    strb = 4'hf;
    chk(chargerDetectOff, 1'h1);
    rd(ADDR_CTRL);
    chk(rv, {16'h0, THR_RESET, 8'h04});
    wr(ADDR_CTRL, {16'h0, THR_RESET, 8'h00});
    chk(chargerDetectOff, 1'h0);
  endtask
  task automatic t_dev_resume();
    ev(1, 1'h1);
    wr(ADDR_PORT, 32'h3);
    chk(phy_low_power_suspend, 1'h1);
    wr(ADDR_PORT, 32'h7);
    settle();
    chk(resumeSeen, 1'h0);
    ev(0, 1'h1);
    settle();
    chk(phy_low_power_suspend, 1'h0);
    chk(irq, 1'h0);
    wr(ADDR_IRQ_MASK, 32'h1f);
    chk(irq, 1'h1);
    rd(ADDR_IRQ_STAT);
    chk(rv, 32'h1);
    wr(ADDR_IRQ_STAT, 32'h1);
    chk(irq, 1'h0);
    wr(ADDR_PORT, 32'h4);
    settle();
    chk(resumeSeen, 1'h1);
  endtask
  task automatic t_host_wake();
    wr(ADDR_CTRL, {16'h0, THR_RESET, 8'h01});
    @(posedge core_clk);
    uss_usb_peer_i.deviceAttached <= 1'h1;
    wr(ADDR_PORT, 32'h2);
    rd(ADDR_PORT);
    chk(rv & 32'h3, 32'h0);
    wr(ADDR_PORT, 32'h1);
    ev(0, 1'h1);
    settle();
    chk(phy_low_power_suspend, 1'h0);
    rd(ADDR_IRQ_STAT);
    chk(rv, 32'h1);
    wr(ADDR_IRQ_STAT, 32'h1f);
    wr(ADDR_PORT, 32'h3);
    chk(phy_low_power_suspend, 1'h1);
    ev(0, 1'h1);
    settle();
    rd(ADDR_IRQ_STAT);
    chk(rv, 32'h2);
    wr(ADDR_IRQ_STAT, 32'h1f);
    wr(ADDR_PWD, 32'hff);
    wr(ADDR_CLK_GATE, 32'h1);
    chk({phy_clock_gate, phy_power_down_bits, phy_low_power_suspend}, 10'h3ff);
    ev(0, 1'h1);
    settle();
    rd(ADDR_IRQ_STAT);
    chk(rv, 32'h0);
  endtask
  task automatic t_rx();
    ev(2, 1'h0);
    #1;
    chk({rxHandshake, rxDiscard, rxError}, 3'h3);
    ev(2, 1'h1);
    #1;
    chk({rxHandshake, rxDiscard, rxError}, 3'h4);
    rd(ADDR_IRQ_STAT);
    chk(rv, 32'h10);
    wr(ADDR_IRQ_STAT, 32'h1f);
    wr(ADDR_CTRL, {16'h0, THR_RESET, 8'h00});
    @(posedge core_clk);
    uss_usb_peer_i.rxOverrun <= 1'h1;
    settle();
    chk(tokenAnswerEn, 1'h0);
    rd(ADDR_STATUS);
    chk(rv, 32'h6);
    ev(2, 1'h1);
    #1;
    chk(rxHandshake, 1'h0);
    @(posedge core_clk);
    uss_usb_peer_i.rxOverrun <= 1'h0;
    settle();
    chk(tokenAnswerEn, 1'h1);
    rd(ADDR_IRQ_STAT);
    chk(rv, 32'h8);
    wr(ADDR_IRQ_STAT, 32'h1f);
  endtask
  task automatic t_tx();
    wr(ADDR_CTRL, 32'h0000_0203);
    wr(ADDR_TX_PKT, 32'h8000_0008);
    load(7);
    settle();
    chk(txActive, 1'h0);
    load(1);
    wait_tx(1'h1);
    wait_tx(1'h0);
    rd(ADDR_IRQ_STAT);
    chk(rv, 32'h0);
    sendGap = 4'h0;
    wr(ADDR_CTRL, 32'h0000_0201);
    // out buffer starts word aligned, so the retry is the only hazard
    wr(ADDR_TX_PKT, 32'h8000_0006);
    load(2);
    wait_tx(1'h1);
    wait_tx(1'h0);
    rd(ADDR_IRQ_STAT);
    chk(rv, 32'h4);
    chk(retrySeen, 1'h0);
    load(4);
    wait_tx(1'h1);
    settle();
    chk(retrySeen, 1'h1);
    wait_tx(1'h0);
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    reset <= 1'h0;
    t_reset();
    t_dev_resume();
    t_host_wake();
    t_rx();
    t_tx();
    report_and_stop();
  end
endmodule

/* verif/uss_ctrl_sva.sv */
// assertions on the ports of uss_ctrl, attached by bind
// assumes the master offers write address and data in the same cycle
`timescale 1ns/10ps
module uss_ctrl_sva
  import uss_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        irq,
  input wire logic        phy_low_power_suspend,
  input wire logic        resumeDrive,
  input wire logic        tokenAnswerEn,
  input wire logic        lineResume,
  input wire logic        rxOverrun,
  input wire logic        rxPacketEnd,
  input wire logic        rxAcceptable,
  input wire logic        rxHandshake,
  input wire logic        rxDiscard,
  input wire logic        rxError,
  input wire logic        txStart,
  input wire logic        txActive,
  input wire logic        txRetry
);
  logic hostMode;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // shadow of the mode bit, taken at the write handshake
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hostMode <= 1'h0;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                 && s_axi_awaddr == ADDR_CTRL && s_axi_wstrb[0]) begin
      hostMode <= s_axi_wdata[CTRL_HOST_BIT];
    end
  end
  a_resume_clears_lps: assert property (
    !hostMode && lineResume |=> !phy_low_power_suspend) else $error("lps kept on resume");
  a_resume_when_awake: assert property (
    resumeDrive |-> !phy_low_power_suspend && !hostMode) else $error("resume while lps");
  a_lps_stays_clear: assert property (
    hostMode && lineResume && !phy_low_power_suspend && s_axi_awready
    |=> !phy_low_power_suspend) else $error("lps set by wakeup");
  // a clear lands as awready returns, so two idle cycles rule out a write
  a_irq_sticky: assert property (irq && s_axi_awready && $past(s_axi_awready) |=> irq)
    else $error("irq dropped without a write");
  a_overrun_blocks: assert property (
    !hostMode && $rose(rxOverrun) |=> !tokenAnswerEn) else $error("tokens still answered");
  a_overrun_recovers: assert property ($fell(rxOverrun) |=> tokenAnswerEn)
    else $error("tokens not resumed");
  a_rx_reject: assert property (
    hostMode && rxPacketEnd && !rxAcceptable |=> rxDiscard && rxError && !rxHandshake)
    else $error("bad packet not dropped");
  a_rx_accept: assert property (
    rxPacketEnd && rxAcceptable && !rxOverrun |=> rxHandshake && !rxError && !rxDiscard)
    else $error("good packet not answered");
  a_retry_restarts: assert property (txRetry |-> txStart && txActive)
    else $error("retry without start");
  c_retry: cover property (txRetry);
  c_rx_error: cover property (rxError);
  c_irq: cover property ($rose(irq));
endmodule
bind uss_ctrl uss_ctrl_sva uss_ctrl_sva_i (.*);

/* verif/uss_usb_peer.sv */
// usb peer across the line: suspend, resume and packet events, byte takes
// assumes the bench calls event_pulse from one process at a time
`timescale 1ns/10ps
module uss_usb_peer (
  input  wire logic       core_clk,
  input  wire logic       txActive,
  input  wire logic [3:0] sendGap,
  output logic            deviceAttached,
  output logic            busSuspendSeen,
  output logic            lineResume,
  output logic            rxOverrun,
  output logic            rxPacketEnd,
  output logic            rxAcceptable,
  output logic            txSendStrobe
);
  logic [3:0] gapCount;
  initial begin
    {deviceAttached, busSuspendSeen, lineResume, rxOverrun} = 4'h0;
    {rxPacketEnd, rxAcceptable, txSendStrobe} = 3'h0;
    gapCount = 4'h0;
  end
  // takes one byte every sendGap+2 cycles, never while idle
  always @(posedge core_clk) begin
    txSendStrobe <= txActive && !txSendStrobe && gapCount == sendGap;
    if (!txActive || txSendStrobe || gapCount == sendGap) begin
      gapCount <= 4'h0;
    end else begin
      gapCount <= gapCount + 4'h1;
    end
  end
  // kind 0 resume, 1 suspend, else packet end; acceptance flips once released
  task automatic event_pulse(input int kind, input logic ok);
    @(posedge core_clk);
    lineResume <= kind == 0;
    busSuspendSeen <= kind == 1;
    rxPacketEnd <= kind > 1;
    rxAcceptable <= ok;
    @(posedge core_clk);
    lineResume <= 1'h0;
    busSuspendSeen <= 1'h0;
    rxPacketEnd <= 1'h0;
    rxAcceptable <= ~ok;
  endtask
endmodule
